// ===== verilog/cis_init_seq.v
// controller initialization and looping self-test sequencer
// Function
// - init starts on power-on, firmware reset, reset button or host clear
// - builtin test, then integrity test, then diagnostic monitor, in order
// - whole initialization must finish within one minute of trigger
// - builtin failure: all port lamps dark, reset lamp steady on
// - builtin test fails when the program card is wrong
// - read boot parameter record and configure firmware as first integrity test step
// - program card code computed over card must match stored reference
// - memory fails unless first two megabytes good and at most 16 sections
// - all legal transfer sizes must work, illegal ones be refused
// - registers checked for stuck bits; every journal address written and read
// - firmware copied to shared memory and verified against the card code
// - any integrity phase fault shows a code on the panel
// - initialization continues while at least one device port passes
// - host port failure stops only together with serial port failure
// - cache failure keeps running, on-board shared memory used for caching
// - cache bad unless first megabyte of cache memory passes
// - cache tests deferred while peer holds lock; controller then memory
// - controller test inits all, full address; manager test diag pages only
// - any interrupt during cache testing stops init and shows a code
// - self-test loops monitor tests, halts on first fault
// - self-test entry drains outstanding I/O and tries a cache flush
// - self-test disconnects host port, device ports untouched
`timescale 1ns/1ps
`include "cis_regs.vh"
module cis_init_seq #(
  parameter PORTS = 6,
  parameter [35:0] INIT_LIMIT_CYC = `CIS_INIT_LIMIT_CYC
) (
  input wire clk_sys,
  input wire reset_n,
  input wire fw_reset_req,
  input wire reset_button_n,
  input wire host_clear,
  input wire program_card_ok,
  input wire peer_cache_lock,
  input wire looping_test_command,
  input wire cache_test_rw,
  input wire irq_any,
  input wire io_idle,
  input wire flush_done,
  input wire test_done,
  input wire test_pass,
  input wire [31:0] test_value,
  input wire [31:0] card_code_ref,
  output reg test_start_q,
  output reg [4:0] test_sel_q,
  output reg [2:0] test_mode_q,
  output reg [1:0] phase_q,
  output reg [7:0] fail_code_q,
  output reg init_done_q,
  output reg init_stopped_q,
  output reg looping_test_command_q,
  output reg host_disconnect_q,
  output reg io_drain_req_q,
  output reg cache_flush_req_q,
  output reg cache_bad_q,
  output reg use_shared_cache_q,
  output reg dsp_bad_q,
  output reg host_bad_q,
  output reg reset_led_q,
  output reg [PORTS-1:0] port_led_q,
  output reg deadline_miss_q
);
  localparam [2:0] S_ISSUE = 3'h0;
  localparam [2:0] S_WAIT = 3'h1;
  localparam [2:0] S_DEFER = 3'h2;
  localparam [2:0] S_DONE = 3'h3;
  localparam [2:0] S_DRAIN = 3'h4;
  localparam [2:0] S_FLUSH = 3'h5;
  localparam [2:0] S_HALT = 3'h6;

  function [1:0] phase_of;
    input [4:0] step;
    begin
      if (step == `CIS_ST_PBIST) begin
        phase_of = `CIS_PH_BUILTIN;
      end else if (step <= `CIS_ST_FW_VERIFY) begin
        phase_of = `CIS_PH_INTEGRITY;
      end else if (step == `CIS_ST_CACHE_MEM) begin
        phase_of = `CIS_PH_FUNCTIONAL;
      end else begin
        phase_of = `CIS_PH_MONITOR;
      end
    end
  endfunction

  // pins from outside the clock domain pass two flops first
  reg [1:0] btn_sync_q;
  reg [1:0] clr_sync_q;
  reg [1:0] card_sync_q;
  reg [1:0] lock_sync_q;
  reg btn_prev_q;
  reg clr_prev_q;
  reg [2:0] state_q;
  reg [4:0] step_q;
  reg deadline_restart_q;
  wire deadline_hit;
  wire btn_press;
  wire clr_rise;
  wire trigger;
  wire cache_step;
  wire [`CIS_MEM_SECT_W-1:0] sections;
  reg step_ok;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      btn_sync_q <= 2'b11;
      clr_sync_q <= 2'b00;
      card_sync_q <= 2'b00;
      lock_sync_q <= 2'b00;
      btn_prev_q <= 1'b1;
      clr_prev_q <= 1'b0;
    end else begin
      btn_sync_q <= {btn_sync_q[0], reset_button_n};
      clr_sync_q <= {clr_sync_q[0], host_clear};
      card_sync_q <= {card_sync_q[0], program_card_ok};
      lock_sync_q <= {lock_sync_q[0], peer_cache_lock};
      btn_prev_q <= btn_sync_q[1];
      clr_prev_q <= clr_sync_q[1];
    end
  end

  assign btn_press = btn_prev_q && !btn_sync_q[1];
  assign clr_rise = clr_sync_q[1] && !clr_prev_q;
  assign trigger = fw_reset_req || btn_press || clr_rise;
  assign cache_step = (step_q == `CIS_ST_CACHE_CTRL) || (step_q == `CIS_ST_CACHE_MEM);
  assign sections = test_value[`CIS_MEM_SECT_LSB +: `CIS_MEM_SECT_W];

  // the timer runs only until the monitor releases control
  cis_deadline #(
    .LIMIT_CYC(INIT_LIMIT_CYC)
  ) u_deadline (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .restart(deadline_restart_q),
    .run(!init_done_q && !init_stopped_q && !looping_test_command_q),
    .expired_q(deadline_hit)
  );

  always @* begin
    step_ok = test_pass;
    case (step_q)
      `CIS_ST_PBIST: step_ok = test_pass && card_sync_q[1];
      `CIS_ST_CARD_EDC: step_ok = test_pass && (test_value == card_code_ref);
      `CIS_ST_MEM: step_ok = test_pass && test_value[`CIS_MEM_FIRST_OK_BIT] &&
        (sections <= `CIS_MEM_MAX_SECT);
      `CIS_ST_FW_VERIFY: step_ok = test_pass && (test_value == card_code_ref);
      `CIS_ST_DEV_PORTS: step_ok = |test_value[PORTS-1:0];
      `CIS_ST_CACHE_MEM: step_ok = test_pass && test_value[`CIS_MEM_FIRST_OK_BIT];
      default: step_ok = test_pass;
    endcase
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= S_ISSUE;
      step_q <= `CIS_ST_PBIST;
      test_start_q <= 1'b0;
      test_sel_q <= `CIS_ST_PBIST;
      test_mode_q <= 3'h0;
      phase_q <= `CIS_PH_BUILTIN;
      fail_code_q <= `CIS_FC_NONE;
      init_done_q <= 1'b0;
      init_stopped_q <= 1'b0;
      looping_test_command_q <= 1'b0;
      host_disconnect_q <= 1'b0;
      io_drain_req_q <= 1'b0;
      cache_flush_req_q <= 1'b0;
      cache_bad_q <= 1'b0;
      use_shared_cache_q <= 1'b0;
      dsp_bad_q <= 1'b0;
      host_bad_q <= 1'b0;
      reset_led_q <= 1'b0;
      port_led_q <= {PORTS{1'b0}};
      deadline_miss_q <= 1'b0;
      deadline_restart_q <= 1'b1;
    end else if (trigger) begin
      // any trigger reinitializes, including out of the self-test loop
      state_q <= S_ISSUE;
      step_q <= `CIS_ST_PBIST;
      test_start_q <= 1'b0;
      test_sel_q <= `CIS_ST_PBIST;
      test_mode_q <= 3'h0;
      phase_q <= `CIS_PH_BUILTIN;
      fail_code_q <= `CIS_FC_NONE;
      init_done_q <= 1'b0;
      init_stopped_q <= 1'b0;
      looping_test_command_q <= 1'b0;
      host_disconnect_q <= 1'b0;
      io_drain_req_q <= 1'b0;
      cache_flush_req_q <= 1'b0;
      cache_bad_q <= 1'b0;
      use_shared_cache_q <= 1'b0;
      dsp_bad_q <= 1'b0;
      host_bad_q <= 1'b0;
      reset_led_q <= 1'b0;
      port_led_q <= {PORTS{1'b0}};
      deadline_miss_q <= 1'b0;
      deadline_restart_q <= 1'b1;
    end else begin
      test_start_q <= 1'b0;
      deadline_restart_q <= 1'b0;
      phase_q <= phase_of(step_q);
      // stale expiry of the last run is ignored while the timer restarts
      if (deadline_hit && !deadline_restart_q && !init_done_q && !init_stopped_q && !looping_test_command_q) begin
        deadline_miss_q <= 1'b1;
        init_stopped_q <= 1'b1;
        fail_code_q <= `CIS_FC_TIMEOUT;
        state_q <= S_HALT;
      end else begin
        case (state_q)
          S_ISSUE: begin
            // boot record step precedes every other integrity test step
            test_start_q <= 1'b1;
            test_sel_q <= step_q;
            if (step_q == `CIS_ST_CACHE_CTRL) begin
              test_mode_q <= 3'h3;
            end else if (step_q == `CIS_ST_CACHE_MEM) begin
              test_mode_q <= {cache_test_rw, 2'b00};
            end else begin
              test_mode_q <= 3'h0;
            end
            state_q <= S_WAIT;
          end
          S_WAIT: begin
            if (cache_step && irq_any) begin
              init_stopped_q <= 1'b1;
              fail_code_q <= `CIS_FC_INTERRUPT;
              state_q <= S_HALT;
            end else if (test_done) begin
              if (step_q == `CIS_ST_DEV_PORTS) begin
                port_led_q <= test_value[PORTS-1:0];
              end
              if (!step_ok) begin
                fail_code_q <= (step_q == `CIS_ST_PBIST && !card_sync_q[1]) ? `CIS_FC_WRONG_CARD :
                  (`CIS_FC_STEP_BASE + {3'h0, step_q});
              end
              if (!step_ok && looping_test_command_q) begin
                init_stopped_q <= 1'b1;
                state_q <= S_HALT;
              end else if (!step_ok && step_q == `CIS_ST_PBIST) begin
                init_stopped_q <= 1'b1;
                reset_led_q <= 1'b1;
                port_led_q <= {PORTS{1'b0}};
                state_q <= S_HALT;
              end else if (!step_ok && step_q == `CIS_ST_DSP) begin
                dsp_bad_q <= 1'b1;
                step_q <= step_q + 5'h1;
                state_q <= S_ISSUE;
              end else if (!step_ok && step_q == `CIS_ST_HOST_PORT && !dsp_bad_q) begin
                host_bad_q <= 1'b1;
                step_q <= `CIS_ST_CACHE_CTRL;
                state_q <= lock_sync_q[1] ? S_DEFER : S_ISSUE;
                init_done_q <= lock_sync_q[1];
              end else if (!step_ok && cache_step) begin
                cache_bad_q <= 1'b1;
                use_shared_cache_q <= 1'b1;
                init_done_q <= 1'b1;
                state_q <= S_DONE;
              end else if (!step_ok) begin
                init_stopped_q <= 1'b1;
                state_q <= S_HALT;
              end else if (step_q == `CIS_ST_HOST_PORT) begin
                if (lock_sync_q[1]) begin
                  init_done_q <= 1'b1;
                  step_q <= `CIS_ST_CACHE_CTRL;
                  state_q <= looping_test_command_q ? S_ISSUE : S_DEFER;
                  if (looping_test_command_q) begin
                    step_q <= `CIS_ST_DEV_PORTS;
                  end
                end else begin
                  step_q <= `CIS_ST_CACHE_CTRL;
                  state_q <= S_ISSUE;
                end
              end else if (step_q == `CIS_ST_CACHE_CTRL) begin
                // monitor releases control here, manager tests memory next
                init_done_q <= 1'b1;
                step_q <= `CIS_ST_CACHE_MEM;
                state_q <= S_ISSUE;
              end else if (step_q == `CIS_ST_CACHE_MEM) begin
                step_q <= `CIS_ST_DEV_PORTS;
                state_q <= looping_test_command_q ? S_ISSUE : S_DONE;
              end else begin
                step_q <= step_q + 5'h1;
                state_q <= S_ISSUE;
              end
            end
          end
          S_DEFER: begin
            if (looping_test_command) begin
              looping_test_command_q <= 1'b1;
              host_disconnect_q <= 1'b1;
              io_drain_req_q <= 1'b1;
              state_q <= S_DRAIN;
            end else if (!lock_sync_q[1]) begin
              step_q <= `CIS_ST_CACHE_CTRL;
              state_q <= S_ISSUE;
            end
          end
          S_DONE: begin
            if (looping_test_command) begin
              looping_test_command_q <= 1'b1;
              host_disconnect_q <= 1'b1;
              io_drain_req_q <= 1'b1;
              state_q <= S_DRAIN;
            end
          end
          S_DRAIN: begin
            if (io_idle) begin
              io_drain_req_q <= 1'b0;
              cache_flush_req_q <= 1'b1;
              state_q <= S_FLUSH;
            end
          end
          S_FLUSH: begin
            // flush outcome is not checked; the loop starts either way
            if (flush_done) begin
              cache_flush_req_q <= 1'b0;
              step_q <= `CIS_ST_DEV_PORTS;
              state_q <= S_ISSUE;
            end
          end
          S_HALT: begin
            state_q <= S_HALT;
          end
          default: begin
            state_q <= S_HALT;
          end
        endcase
      end
    end
  end
endmodule // cis_init_seq

// ===== verilog/cis_regs.vh
// constants for the controller initialization self-test sequencer
`ifndef CIS_REGS_VH
`define CIS_REGS_VH

// clock rate and the whole-initialization time budget
`define CIS_CLK_HZ 36'd100000000
`define CIS_INIT_LIMIT_S 36'd60
`define CIS_INIT_LIMIT_CYC (`CIS_INIT_LIMIT_S * `CIS_CLK_HZ)

// test step selectors, in execution order
`define CIS_ST_PBIST 5'h00
`define CIS_ST_BOOT 5'h01
`define CIS_ST_CARD_EDC 5'h02
`define CIS_ST_TIMER 5'h03
`define CIS_ST_DSP 5'h04
`define CIS_ST_MEM 5'h05
`define CIS_ST_XFER 5'h06
`define CIS_ST_PARITY 5'h07
`define CIS_ST_REGS 5'h08
`define CIS_ST_JOURNAL 5'h09
`define CIS_ST_ICACHE 5'h0a
`define CIS_ST_FW_COPY 5'h0b
`define CIS_ST_FW_VERIFY 5'h0c
`define CIS_ST_DEV_PORTS 5'h0d
`define CIS_ST_HOST_PORT 5'h0e
`define CIS_ST_CACHE_CTRL 5'h0f
`define CIS_ST_CACHE_MEM 5'h10

// phases shown to the panel
`define CIS_PH_BUILTIN 2'h0
`define CIS_PH_INTEGRITY 2'h1
`define CIS_PH_MONITOR 2'h2
`define CIS_PH_FUNCTIONAL 2'h3

// failure codes: step failures are base plus step selector
`define CIS_FC_NONE 8'h00
`define CIS_FC_STEP_BASE 8'h40
`define CIS_FC_WRONG_CARD 8'h21
`define CIS_FC_INTERRUPT 8'h22
`define CIS_FC_TIMEOUT 8'h23

// memory test result layout on test_value
`define CIS_MEM_FIRST_OK_BIT 31
`define CIS_MEM_SECT_LSB 0
`define CIS_MEM_SECT_W 8
`define CIS_MEM_MAX_SECT 8'h10

// cache test mode bits
`define CIS_MODE_INIT_ALL 0
`define CIS_MODE_FULL_ADDR 1
`define CIS_MODE_RW 2

`endif

// ===== verilog/cis_deadline.v
// deadline counter for the initialization time budget
`timescale 1ns/1ps
module cis_deadline #(
  parameter [35:0] LIMIT_CYC = 36'd6000000000
) (
  input wire clk_sys,
  input wire reset_n,
  input wire restart,
  input wire run,
  output reg expired_q
);
  reg [35:0] count_q;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 36'h0;
      expired_q <= 1'b0;
    end else if (restart) begin
      count_q <= 36'h0;
      expired_q <= 1'b0;
    end else if (run && !expired_q) begin
      count_q <= count_q + 36'h1;
      if (count_q >= LIMIT_CYC - 36'h1) begin
        expired_q <= 1'b1;
      end
    end
  end
endmodule // cis_deadline

// ===== verification/cis_engine_model.sv
// test engine model answering the sequencer's step requests
`timescale 1ns/1ps
`include "cis_regs.vh"
module cis_engine_model (
  input wire clk_sys,
  input wire reset_n,
  input wire test_start_q,
  input wire [4:0] test_sel_q,
  input wire [16:0] fail_mask,
  input wire [7:0] dly,
  input wire [5:0] dev_val,
  input wire [31:0] card_code,
  input wire [7:0] sect,
  output reg test_done,
  output reg test_pass,
  output reg [31:0] test_value
);
  reg busy_q;
  reg [7:0] cnt_q;
  reg [4:0] sel_q;
  wire bad = fail_mask[sel_q];
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
      sel_q <= 5'h00;
      test_done <= 1'b0;
      test_pass <= 1'b0;
      test_value <= 32'h00000000;
    end else begin
      test_done <= 1'b0;
      // stale result scrambled so it never passes for a fresh one
      test_value <= ~test_value;
      test_pass <= ~test_pass;
      if (test_start_q) begin
        busy_q <= 1'b1;
        cnt_q <= dly;
        sel_q <= test_sel_q;
      end else if (busy_q && cnt_q == 8'h00) begin
        busy_q <= 1'b0;
        test_done <= 1'b1;
        test_pass <= !bad;
        case (sel_q)
          // pass stays high so only the reported value can fail these steps
          `CIS_ST_CARD_EDC, `CIS_ST_FW_VERIFY: begin
            test_pass <= 1'b1;
            test_value <= bad ? ~card_code : card_code;
          end
          `CIS_ST_MEM: begin
            test_pass <= 1'b1;
            test_value <= {!bad, 23'h000000, sect};
          end
          `CIS_ST_DEV_PORTS: begin
            test_pass <= |dev_val;
            test_value <= {26'h0000000, dev_val};
          end
          `CIS_ST_CACHE_MEM: begin
            test_pass <= 1'b1;
            test_value <= {!bad, 31'h00000000};
          end
          default: test_value <= 32'h00000000;
        endcase
      end else if (busy_q) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule // cis_engine_model

// ===== verification/cis_init_seq_monitor.sv
// assertions on the sequencer ports
`timescale 1ns/1ps
`include "cis_regs.vh"
module cis_init_seq_monitor #(
  parameter PORTS = 6
) (
  input wire clk_sys,
  input wire reset_n,
  input wire io_idle,
  input wire cache_test_rw,
  input wire test_start_q,
  input wire [4:0] test_sel_q,
  input wire [2:0] test_mode_q,
  input wire [1:0] phase_q,
  input wire [7:0] fail_code_q,
  input wire init_stopped_q,
  input wire looping_test_command_q,
  input wire host_disconnect_q,
  input wire io_drain_req_q,
  input wire cache_flush_req_q,
  input wire cache_bad_q,
  input wire use_shared_cache_q,
  input wire reset_led_q,
  input wire [PORTS-1:0] port_led_q,
  input wire deadline_miss_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_start_one_pulse: assert property (test_start_q |=> !test_start_q) else $error("start pulse too long");
  a_builtin_lamps_dark: assert property (reset_led_q |-> init_stopped_q && port_led_q == 0)
    else $error("port lamps lit after builtin failure");
  a_looping_test_command_host_off: assert property (looping_test_command_q |-> host_disconnect_q) else $error("host still on");
  a_looping_test_command_drain: assert property ($rose(looping_test_command_q) |-> io_drain_req_q) else $error("no io drain");
  a_drain_then_flush: assert property (io_drain_req_q && io_idle |=> !io_drain_req_q && cache_flush_req_q)
    else $error("flush not requested");
  a_ctrl_test_mode: assert property (test_start_q && test_sel_q == `CIS_ST_CACHE_CTRL |-> test_mode_q == 3'h3)
    else $error("controller test mode wrong");
  a_mem_test_mode: assert property (test_start_q && test_sel_q == `CIS_ST_CACHE_MEM
    |-> test_mode_q == {$past(cache_test_rw), 2'h0}) else $error("memory test mode wrong");
  a_cache_fallback: assert property ($rose(cache_bad_q) |-> use_shared_cache_q && !init_stopped_q)
    else $error("no shared memory fallback");
  a_monitor_phase: assert property (test_start_q && test_sel_q == `CIS_ST_DEV_PORTS
    |-> ##[0:1] phase_q == `CIS_PH_MONITOR) else $error("port test outside monitor phase");
  a_timeout_code: assert property ($rose(deadline_miss_q) |-> ##[0:2] fail_code_q == `CIS_FC_TIMEOUT)
    else $error("timeout code missing");
  c_looping_test_command: cover property ($rose(looping_test_command_q));
  c_cache_bad: cover property ($rose(cache_bad_q));
  c_deadline: cover property ($rose(deadline_miss_q));
endmodule // cis_init_seq_monitor

// ===== verification/cis_init_seq_tb_top.sv
// testbench for the initialization sequencer
`timescale 1ns/1ps
`include "cis_regs.vh"
module cis_init_seq_tb_top;
  localparam [31:0] CODE = 32'h5a5a0f0f;
  reg clk_sys, reset_n, fw_reset_req, reset_button_n, host_clear, program_card_ok, irq_arm;
  reg peer_cache_lock, looping_test_command, cache_test_rw, irq_any, io_idle, flush_done;
  reg [16:0] fail_mask;
  reg [7:0] dly, sect;
  reg [5:0] dev_val;
  wire test_done, test_pass, test_start_q, init_done_q, init_stopped_q, looping_test_command_q, host_disconnect_q;
  wire io_drain_req_q, cache_flush_req_q, cache_bad_q, use_shared_cache_q, dsp_bad_q, host_bad_q;
  wire reset_led_q, deadline_miss_q;
  wire [31:0] test_value;
  wire [4:0] test_sel_q;
  wire [2:0] test_mode_q;
  wire [1:0] phase_q;
  wire [7:0] fail_code_q;
  wire [5:0] port_led_q;
  int miscompares, tests_run, n, k;
  reg [4:0] seq[$];
  reg [4:0] bad[6] = '{5'h02, 5'h05, 5'h06, 5'h08, 5'h09, 5'h0c};
  cis_init_seq #(.PORTS(6), .INIT_LIMIT_CYC(36'd2000)) cis_init_seq_inst (.clk_sys, .reset_n, .fw_reset_req,
    .reset_button_n, .host_clear, .program_card_ok, .peer_cache_lock, .looping_test_command, .cache_test_rw,
    .irq_any, .io_idle, .flush_done, .test_done, .test_pass, .test_value, .card_code_ref(CODE), .test_start_q,
    .test_sel_q, .test_mode_q, .phase_q, .fail_code_q, .init_done_q, .init_stopped_q, .looping_test_command_q,
    .host_disconnect_q, .io_drain_req_q, .cache_flush_req_q, .cache_bad_q, .use_shared_cache_q, .dsp_bad_q,
    .host_bad_q, .reset_led_q, .port_led_q, .deadline_miss_q);
  cis_engine_model cis_engine_model_inst (.clk_sys, .reset_n, .test_start_q, .test_sel_q, .fail_mask, .dly,
    .dev_val, .card_code(CODE), .sect, .test_done, .test_pass, .test_value);
  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (test_start_q === 1'b1) seq.push_back(test_sel_q);
  // interrupt lands while the cache controller test is still waiting
  always @(posedge clk_sys) if (irq_arm && test_start_q === 1'b1 && test_sel_q == 5'h0f) irq_any <= 1;
  task check(input [31:0] seen, input [31:0] exp);
    begin
      tests_run++;
      if (seen !== exp) begin
        miscompares++;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task wait_end(input bit stop_only);
    begin
      n = 0;
      while (!(init_stopped_q === 1 || (!stop_only && init_done_q === 1)) && n < 4000) begin
        @(posedge clk_sys);
        n++;
      end
      if (n >= 4000) miscompares++;
      // done rises before the cache manager step has finished
      repeat (12) @(posedge clk_sys);
      #1;
    end
  endtask
  task run(input int kind);
    begin
      @(posedge clk_sys);
      if (kind == 0) fw_reset_req <= 1;
      else if (kind == 1) reset_button_n <= 0;
      else host_clear <= 1;
      repeat (4) @(posedge clk_sys);
      fw_reset_req <= 0;
      reset_button_n <= 1;
      host_clear <= 0;
      repeat (4) @(posedge clk_sys);
      wait_end(0);
    end
  endtask
  task t_normal;
    begin
      wait_end(0);
      check(seq.size(), 17);
      foreach (seq[i]) check(seq[i], i);
      check(init_done_q, 1);
      check(deadline_miss_q, 0);
      check(port_led_q, 6'h3f);
      $display("normal init done");
    end
  endtask
  task t_builtin;
    begin
      @(posedge clk_sys) program_card_ok <= 0;
      run(2);
      check(fail_code_q, `CIS_FC_WRONG_CARD);
      check({reset_led_q, port_led_q}, 7'h40);
      check(phase_q, `CIS_PH_BUILTIN);
      @(posedge clk_sys) program_card_ok <= 1;
      $display("builtin test done");
    end
  endtask
  task t_ports;
    begin
      @(posedge clk_sys) dev_val <= 6'h01;
      run(1);
      check({init_done_q, port_led_q}, 7'h41);
      @(posedge clk_sys) dev_val <= 6'h00;
      run(0);
      check({init_stopped_q, fail_code_q}, 9'h14d);
      check(phase_q, `CIS_PH_MONITOR);
      @(posedge clk_sys) dev_val <= 6'h3f;
      $display("port test done");
    end
  endtask
  task t_faults;
    begin
      for (k = 0; k < 6; k++) begin
        @(posedge clk_sys) fail_mask <= 17'h1 << bad[k];
        run(0);
        check({init_stopped_q, fail_code_q}, {1'b1, 8'h40 + bad[k]});
        check(seq[$], bad[k]);
        check(phase_q, `CIS_PH_INTEGRITY);
      end
      // sixteen sections is the limit that still passes
      for (k = 0; k < 2; k++) begin
        @(posedge clk_sys) fail_mask <= 0;
        sect <= k ? 8'h11 : 8'h10;
        run(0);
        check({init_stopped_q, fail_code_q}, k ? 9'h145 : 9'h000);
      end
      @(posedge clk_sys) sect <= 8'h01;
      for (k = 0; k < 3; k++) begin
        @(posedge clk_sys) fail_mask <= (k != 1 ? 17'h04000 : 17'h0) | (k != 0 ? 17'h00010 : 17'h0);
        run(0);
        check({init_stopped_q, init_done_q, dsp_bad_q | host_bad_q}, k == 2 ? 3'h5 : 3'h3);
      end
      check(fail_code_q, 8'h4e);
      $display("fault tests done");
    end
  endtask
  task t_cache;
    begin
      @(posedge clk_sys) fail_mask <= 17'h10000;
      cache_test_rw <= 1;
      run(0);
      check({init_done_q, cache_bad_q, use_shared_cache_q}, 3'h7);
      @(posedge clk_sys) fail_mask <= 0;
      irq_arm <= 1;
      run(0);
      check({init_stopped_q, fail_code_q}, 9'h122);
      @(posedge clk_sys) irq_arm <= 0;
      irq_any <= 0;
      peer_cache_lock <= 1;
      run(0);
      repeat (20) @(posedge clk_sys);
      check(seq[$], 5'h0e);
      peer_cache_lock <= 0;
      for (n = 0; n < 300 && seq[$] != 5'h10; n++) @(posedge clk_sys);
      check({seq[$-1], seq[$]}, 10'h1f0);
      $display("cache tests done");
    end
  endtask
  task t_self;
    begin
      run(0);
      @(posedge clk_sys) looping_test_command <= 1;
      @(posedge clk_sys) looping_test_command <= 0;
      repeat (2) @(posedge clk_sys);
      check({looping_test_command_q, host_disconnect_q, io_drain_req_q}, 3'h7);
      io_idle <= 1;
      repeat (3) @(posedge clk_sys);
      check(cache_flush_req_q, 1);
      flush_done <= 1;
      @(posedge clk_sys) flush_done <= 0;
      k = seq.size();
      for (n = 0; n < 400 && seq.size() < k + 8; n++) @(posedge clk_sys);
      for (n = 0; n < 8; n++) check(seq[k + n], 13 + n % 4);
      fail_mask <= 17'h04000;
      wait_end(1);
      check(init_stopped_q, 1);
      @(posedge clk_sys) fail_mask <= 0;
      io_idle <= 0;
      dly <= 200;
      run(0);
      check({deadline_miss_q, fail_code_q}, 9'h123);
      // a single-edge trigger must not inherit the expired timer
      @(posedge clk_sys) dly <= 3;
      run(1);
      check({deadline_miss_q, init_done_q}, 2'h1);
      $display("self-test and deadline done");
    end
  endtask
  task close_out;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial begin
    {fw_reset_req, host_clear, peer_cache_lock, looping_test_command, cache_test_rw, irq_any, irq_arm} = 0;
    {io_idle, flush_done, reset_n, fail_mask, miscompares, tests_run} = 0;
    {reset_button_n, program_card_ok, dly, dev_val, sect} = {2'h3, 8'h03, 6'h3f, 8'h01};
    repeat (10) @(posedge clk_sys);
    reset_n <= 1;
    t_normal;
    t_builtin;
    t_ports;
    t_faults;
    t_cache;
    t_self;
    close_out;
  end
  initial begin
    #1000000;
    miscompares++;
    close_out;
  end
endmodule // cis_init_seq_tb_top
bind cis_init_seq cis_init_seq_monitor #(.PORTS(PORTS)) cis_init_seq_monitor_inst (.clk_sys, .reset_n, .io_idle,
  .cache_test_rw, .test_start_q, .test_sel_q, .test_mode_q, .phase_q, .fail_code_q, .init_stopped_q, .looping_test_command_q,
  .host_disconnect_q, .io_drain_req_q, .cache_flush_req_q, .cache_bad_q, .use_shared_cache_q, .reset_led_q,
  .port_led_q, .deadline_miss_q);
